/* File: rtl/frc_pkg.sv */
/*
  Constants, commands and defaults for the FIFO reset and retransmit control.
  Assumes one system clock; both ends import the whole package.
*/
// Behaviour
// - Retransmit taken at read edge with retransmit_n low
// - Enables high before retransmit_n goes low
// - Between reset and retransmit: 2..depth-2 words
// - Depth D, plus one in fall-through mode
// - Standard retransmit: empty flag low, pointer rewinds
// - Standard: flag high ends setup, reads need enable
// - Fall-through retransmit: ready high, pointer rewinds
// - Fall-through: ready low shows first word unasked
// - Almost-empty updated second read edge after setup
// - Half-full updated at the setup read edge
// - Almost-full updated second write edge after setup
// - Master reset: pointers cleared, partial flags preset
// - Master reset latches timing mode and offset method
// - Load low: offsets 127, parallel method
// - Load high: offsets 1023, serial method
// - Master reset zeroes output; no write before it
// - Partial reset: pointers cleared, partial flags preset
// - Partial reset keeps mode, presets mode flags
// - Partial reset keeps offsets, zeroes output
// - Fall-through first word shows after three edges
// - Mode pin is serial input after master reset; the device ignores it then
// - Half-full driven low only at write edges and retransmit setup
// - Write enable ignored when full
// - Read enable ignored when empty
package frc_pkg;

  localparam int DEPTH_DEF = 262144;
  localparam int DATA_W = 9;
  localparam int OFF_W = 10;
  localparam logic [OFF_W-1:0] OFF_DEF_PAR = 10'h07F;
  localparam logic [OFF_W-1:0] OFF_DEF_SER = 10'h3FF;
  localparam logic [1:0] RT_SETUP_EDGES = 2'h2;
  localparam logic [1:0] FT_LAT_EDGES = 2'h3;
  localparam logic [1:0] FLAG_SYNC_EDGES = 2'h2;

  typedef enum logic [2:0] {
    FRC_OP_WRITE = 3'h0,
    FRC_OP_READ = 3'h1,
    FRC_OP_RCLK = 3'h2,
    FRC_OP_WCLK = 3'h3,
    FRC_OP_RETRANSMIT = 3'h4,
    FRC_OP_MASTER_RESET = 3'h5,
    FRC_OP_PARTIAL_RESET = 3'h6
  } frc_op_t;

endpackage : frc_pkg

/* File: rtl/frc_if.sv */
/*
  Pin bundle between the FIFO device and its writer and reader.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface frc_if
  import frc_pkg::*;
  ();
  logic write_clock;
  logic write_enable_n;
  logic [DATA_W-1:0] data_in;
  logic read_clock;
  logic read_enable_n;
  logic retransmit_n;
  logic master_reset_n;
  logic partial_reset_n;
  logic offset_load_n;
  logic mode_select_serial_in;
  logic [DATA_W-1:0] data_out;
  logic empty_flag_n;
  logic output_ready_n;
  logic full_flag_n;
  logic input_ready_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;
  logic half_full_flag_n;

  modport dev (
    input write_clock, write_enable_n, data_in, read_clock, read_enable_n,
    input retransmit_n, master_reset_n, partial_reset_n, offset_load_n,
    input mode_select_serial_in,
    output data_out, empty_flag_n, output_ready_n, full_flag_n,
    output input_ready_n, almost_empty_flag_n, almost_full_flag_n,
    output half_full_flag_n
  );

  modport host (
    output write_clock, write_enable_n, data_in, read_clock, read_enable_n,
    output retransmit_n, master_reset_n, partial_reset_n, offset_load_n,
    output mode_select_serial_in,
    input data_out, empty_flag_n, output_ready_n, full_flag_n,
    input input_ready_n, almost_empty_flag_n, almost_full_flag_n,
    input half_full_flag_n
  );
endinterface : frc_if

/* File: rtl/frc_device.sv */
/*
  FIFO device end: storage, pointers, flags, resets and retransmit.
  Assumes link clocks and controls are synchronous to CLK and that each
  link clock level lasts at least one CLK cycle.
*/
`timescale 1ns/1ps
module frc_device
  import frc_pkg::*;
  #(
  parameter int DEPTH = DEPTH_DEF
  )(
  input wire logic CLK,
  input wire logic RESET_N,
  frc_if.dev LINK,
  output logic FALL_THROUGH_MODE_ACTIVE,
  output logic [$clog2(DEPTH+2)-1:0] OCCUPANCY
  );

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+2);
  localparam int XW = (CW > OFF_W ? CW : OFF_W) + 1;

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("DEPTH must be a power of two of at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic inited;
    logic fall_through_mode;
    logic serial;
    logic [OFF_W-1:0] ae_off;
    logic [OFF_W-1:0] af_off;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic valid;
    logic [DATA_W-1:0] dout;
    logic [1:0] ft_cnt;
    logic [1:0] rt_cnt;
    logic rt_busy;
    logic [1:0] ae_hold;
    logic [1:0] af_hold;
    logic ef;
    logic ff;
    logic ae;
    logic af;
    logic hf;
    logic wclk_d;
    logic rclk_d;
  } frc_dev_t;

  frc_dev_t s;
  frc_dev_t next_s;
  logic [DATA_W-1:0] mem [DEPTH];
  logic do_wr;

  function automatic logic [OFF_W-1:0] def_off(input logic ld_n);
    def_off = ld_n ? OFF_DEF_SER : OFF_DEF_PAR;
  endfunction : def_off

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic wedge;
    logic redge;
    logic rt_take;
    logic load;
    logic occ_half;
    logic [CW-1:0] occ;
    logic [CW-1:0] tot;
    wedge = 1'b0;
    redge = 1'b0;
    rt_take = 1'b0;
    load = 1'b0;
    occ_half = 1'b0;
    occ = '0;
    tot = '0;
    next_s = s;
    do_wr = 1'b0;
    wedge = LINK.write_clock & ~s.wclk_d;
    redge = LINK.read_clock & ~s.rclk_d;
    next_s.wclk_d = LINK.write_clock;
    next_s.rclk_d = LINK.read_clock;
    if (!LINK.master_reset_n || !LINK.partial_reset_n) begin
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.cnt = '0;
      next_s.valid = 1'b0;
      next_s.dout = '0;
      next_s.ft_cnt = '0;
      next_s.rt_cnt = '0;
      next_s.rt_busy = 1'b0;
      next_s.ae_hold = '0;
      next_s.af_hold = '0;
      next_s.ae = 1'b0;
      next_s.af = 1'b1;
      next_s.hf = 1'b1;
      next_s.ef = 1'b0;
      next_s.ff = 1'b1;
      if (!LINK.master_reset_n) begin
        next_s.inited = 1'b1;
        next_s.fall_through_mode = LINK.mode_select_serial_in;
        next_s.serial = LINK.offset_load_n;
        next_s.ae_off = def_off(LINK.offset_load_n);
        next_s.af_off = def_off(LINK.offset_load_n);
      end
    end else if (s.inited) begin
      // Retransmit setup, sampled on the read edge
      rt_take = redge & ~LINK.retransmit_n & ~s.rt_busy;
      // Write side, refused when full
      do_wr = wedge & ~LINK.write_enable_n
        & (s.cnt != CW'(DEPTH));
      if (do_wr) begin
        next_s.wptr = s.wptr + AW'(1);
        next_s.cnt = next_s.cnt + CW'(1);
      end
      if (rt_take) begin
        next_s.rptr = '0;
        next_s.cnt = CW'(s.wptr);
        next_s.valid = 1'b0;
        next_s.ef = 1'b0;
        next_s.rt_busy = 1'b1;
        next_s.rt_cnt = '0;
        next_s.ft_cnt = '0;
        next_s.ae_hold = FLAG_SYNC_EDGES;
        next_s.af_hold = FLAG_SYNC_EDGES;
      end else if (redge && s.rt_busy) begin
        next_s.rt_cnt = s.rt_cnt + 2'h1;
        if (s.rt_cnt == RT_SETUP_EDGES - 2'h1) begin
          next_s.rt_busy = 1'b0;
          load = s.fall_through_mode && s.cnt != '0;
        end
      end else if (redge && !s.fall_through_mode) begin
        load = ~LINK.read_enable_n & (s.cnt != '0);
      end else if (redge && s.valid) begin
        if (!LINK.read_enable_n) begin
          load = s.cnt != '0;
          next_s.valid = load;
        end
      end else if (redge && s.cnt != '0) begin
        next_s.ft_cnt = s.ft_cnt + 2'h1;
        if (s.ft_cnt == FT_LAT_EDGES - 2'h1) begin
          load = 1'b1;
          next_s.ft_cnt = '0;
        end
      end
      if (load) begin
        next_s.dout = mem[next_s.rptr];
        next_s.rptr = next_s.rptr + AW'(1);
        next_s.cnt = next_s.cnt - CW'(1);
        next_s.valid = s.fall_through_mode;
      end
      occ = next_s.cnt + CW'(next_s.valid);
      tot = CW'(DEPTH) + CW'(s.fall_through_mode);
      occ_half = occ > CW'(DEPTH / 2);
      if (rt_take) begin
        next_s.hf = ~occ_half;
      end else if (redge && !occ_half) begin
        next_s.hf = 1'b1;
      end
      if (wedge && occ_half) begin
        next_s.hf = 1'b0;
      end
      if (redge && !rt_take) begin
        if (!next_s.rt_busy && !s.fall_through_mode) begin
          next_s.ef = next_s.cnt != '0;
        end
        if (s.ae_hold > 2'h1) begin
          next_s.ae_hold = s.ae_hold - 2'h1;
        end else begin
          next_s.ae_hold = '0;
          next_s.ae = XW'(occ) > XW'(s.ae_off);
        end
      end
      if (wedge) begin
        next_s.ff = next_s.cnt != CW'(DEPTH);
        if (s.af_hold > 2'h1 && !rt_take) begin
          next_s.af_hold = s.af_hold - 2'h1;
        end else if (!rt_take) begin
          next_s.af_hold = '0;
          next_s.af = XW'(occ) + XW'(s.af_off) < XW'(tot);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s <= '0;
      s.ff <= 1'b1;
      s.af <= 1'b1;
      s.hf <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (do_wr) begin
      mem[s.wptr] <= LINK.data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  assign LINK.data_out = s.dout;
  assign LINK.empty_flag_n = s.fall_through_mode | s.ef;
  assign LINK.output_ready_n = ~s.fall_through_mode | ~s.valid;
  assign LINK.full_flag_n = s.fall_through_mode | s.ff;
  assign LINK.input_ready_n = ~s.fall_through_mode | ~s.ff;
  assign LINK.almost_empty_flag_n = s.ae;
  assign LINK.almost_full_flag_n = s.af;
  assign LINK.half_full_flag_n = s.hf;
  assign FALL_THROUGH_MODE_ACTIVE = s.fall_through_mode;
  assign OCCUPANCY = s.cnt + CW'(s.valid);

endmodule : frc_device

/* File: rtl/frc_host.sv */
/*
  Writer and reader end: turns user commands into link pin sequences.
  Assumes one command at a time, taken while CMD_READY is high.
*/
`timescale 1ns/1ps
module frc_host
  import frc_pkg::*;
  #(
  parameter int DEPTH = DEPTH_DEF
  )(
  input wire logic CLK,
  input wire logic RESET_N,
  frc_if.host LINK,
  input wire logic CMD_VALID,
  input wire frc_op_t CMD_OP,
  input wire logic [DATA_W-1:0] CMD_DATA,
  input wire logic CMD_FALL_THROUGH_MODE,
  input wire logic CMD_LOAD_N,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic RSP_REFUSED,
  output logic [DATA_W-1:0] RSP_DATA,
  output logic [6:0] RSP_FLAGS
  );

  localparam int CW = $clog2(DEPTH+2);

  if (DEPTH < 4) begin : g_depth_chk
    $error("DEPTH must be at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_EDGE = 4'h4,
    ST_DONE = 4'h8
  } frc_hst_t;

  typedef struct packed {
    frc_hst_t st;
    frc_op_t op;
    logic wclk;
    logic rclk;
    logic wen_n;
    logic ren_n;
    logic rt_n;
    logic mrs_n;
    logic prs_n;
    logic ld_n;
    logic si;
    logic ft;
    logic [DATA_W-1:0] din;
    logic [CW-1:0] wr_cnt;
    logic [CW-1:0] rd_cnt;
    logic rsp_valid;
    logic refused;
    logic [DATA_W-1:0] rsp_data;
    logic [6:0] flags;
  } frc_host_t;

  frc_host_t s;
  frc_host_t next_s;

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (v == CW'(DEPTH)) ? v : v + CW'(1);
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    logic rt_ok;
    rt_ok = (s.wr_cnt >= CW'(2)) && (s.rd_cnt >= CW'(2))
      && (s.wr_cnt <= CW'(DEPTH - 2));
    next_s = s;
    next_s.rsp_valid = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_s.op = CMD_OP;
          next_s.din = CMD_DATA;
          next_s.refused = 1'b0;
          next_s.st = ST_SETUP;
          case (CMD_OP)
            FRC_OP_WRITE: next_s.wen_n = 1'b0;
            FRC_OP_READ: next_s.ren_n = 1'b0;
            FRC_OP_RETRANSMIT: begin
              // Enables are already high while idle
              next_s.rt_n = ~rt_ok;
              next_s.refused = ~rt_ok;
            end
            FRC_OP_MASTER_RESET: begin
              next_s.mrs_n = 1'b0;
              next_s.si = CMD_FALL_THROUGH_MODE;
              next_s.ft = CMD_FALL_THROUGH_MODE;
              next_s.ld_n = CMD_LOAD_N;
            end
            FRC_OP_PARTIAL_RESET: next_s.prs_n = 1'b0;
            default: next_s.st = ST_SETUP;
          endcase
        end
      end
      ST_SETUP: begin
        next_s.st = ST_EDGE;
        case (s.op)
          FRC_OP_WRITE, FRC_OP_WCLK: next_s.wclk = 1'b1;
          FRC_OP_READ, FRC_OP_RCLK: next_s.rclk = 1'b1;
          FRC_OP_RETRANSMIT: next_s.rclk = 1'b1;
          default: next_s.rclk = 1'b0;
        endcase
      end
      ST_EDGE: begin
        next_s.st = ST_DONE;
        next_s.wclk = 1'b0;
        next_s.rclk = 1'b0;
        next_s.wen_n = 1'b1;
        next_s.ren_n = 1'b1;
        next_s.rt_n = 1'b1;
        next_s.mrs_n = 1'b1;
        next_s.prs_n = 1'b1;
        next_s.ld_n = 1'b1;
        next_s.si = 1'b0;
        if (s.op == FRC_OP_WRITE
            && (s.ft ? !LINK.input_ready_n : LINK.full_flag_n)) begin
          next_s.wr_cnt = sat_inc(s.wr_cnt);
        end
        if (s.op == FRC_OP_READ) begin
          next_s.rd_cnt = sat_inc(s.rd_cnt);
        end
        if (s.op == FRC_OP_MASTER_RESET || s.op == FRC_OP_PARTIAL_RESET) begin
          next_s.wr_cnt = '0;
          next_s.rd_cnt = '0;
        end
      end
      ST_DONE: begin
        next_s.st = ST_IDLE;
        next_s.rsp_valid = 1'b1;
        next_s.rsp_data = LINK.data_out;
        next_s.flags = {LINK.half_full_flag_n, LINK.almost_full_flag_n,
          LINK.almost_empty_flag_n, LINK.input_ready_n, LINK.full_flag_n,
          LINK.output_ready_n, LINK.empty_flag_n};
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.op <= FRC_OP_RCLK;
      s.wen_n <= 1'b1;
      s.ren_n <= 1'b1;
      s.rt_n <= 1'b1;
      s.mrs_n <= 1'b1;
      s.prs_n <= 1'b1;
      s.ld_n <= 1'b1;
      s.flags <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  assign LINK.write_clock = s.wclk;
  assign LINK.read_clock = s.rclk;
  assign LINK.write_enable_n = s.wen_n;
  assign LINK.read_enable_n = s.ren_n;
  assign LINK.retransmit_n = s.rt_n;
  assign LINK.master_reset_n = s.mrs_n;
  assign LINK.partial_reset_n = s.prs_n;
  assign LINK.offset_load_n = s.ld_n;
  assign LINK.mode_select_serial_in = s.si;
  assign LINK.data_in = s.din;
  assign CMD_READY = s.st == ST_IDLE;
  assign RSP_VALID = s.rsp_valid;
  assign RSP_REFUSED = s.refused;
  assign RSP_DATA = s.rsp_data;
  assign RSP_FLAGS = s.flags;

endmodule : frc_host

/* File: test/frc_link_props.sv */
/*
  Link assertions between the FIFO device and its host.
  Assumes all link signals are levels sampled on CLK.
*/
`timescale 1ns/1ps
module frc_link_props
  import frc_pkg::*;
  (
  input logic CLK,
  input logic RESET_N,
  input logic write_clock,
  input logic write_enable_n,
  input logic read_clock,
  input logic retransmit_n,
  input logic master_reset_n,
  input logic partial_reset_n,
  input logic mode_select_serial_in,
  input logic [DATA_W-1:0] data_out,
  input logic empty_flag_n,
  input logic output_ready_n,
  input logic full_flag_n,
  input logic input_ready_n,
  input logic almost_empty_flag_n,
  input logic almost_full_flag_n,
  input logic half_full_flag_n
  );
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  //////////////////////////////////////////////////////////////////////////////
  mrs_flags_a: assert property (
    !master_reset_n |=> !almost_empty_flag_n && almost_full_flag_n
      && half_full_flag_n && data_out == 9'h000)
    else $error("master reset flags wrong");
  mrs_std_a: assert property (
    !master_reset_n && !mode_select_serial_in |=> !empty_flag_n
      && full_flag_n && output_ready_n && input_ready_n)
    else $error("standard mode flags wrong");
  mrs_fall_through_mode_a: assert property (
    !master_reset_n && mode_select_serial_in |=> output_ready_n
      && !input_ready_n && empty_flag_n && full_flag_n)
    else $error("fall-through mode flags wrong");
  prs_flags_a: assert property (
    !partial_reset_n |=> !almost_empty_flag_n && almost_full_flag_n
      && half_full_flag_n && data_out == 9'h000)
    else $error("partial reset flags wrong");
  prs_mode_a: assert property (
    !partial_reset_n |=> full_flag_n && output_ready_n
      && (empty_flag_n != input_ready_n))
    else $error("partial reset mode flags wrong");
  rt_std_a: assert property (
    !retransmit_n && $rose(read_clock) && input_ready_n
      |=> !empty_flag_n [*4])
    else $error("standard retransmit did not mark empty");
  rt_fall_through_mode_a: assert property (
    !retransmit_n && $rose(read_clock) && !input_ready_n
      |=> output_ready_n [*4])
    else $error("fall-through retransmit did not mark ready");
  wr_full_a: assert property (
    !full_flag_n && !write_enable_n && $rose(write_clock)
      && master_reset_n && partial_reset_n
      |=> !full_flag_n && $stable(data_out))
    else $error("write taken while full");
  hf_rise_a: assert property (
    $rose(half_full_flag_n) |-> !$past(master_reset_n)
      || !$past(partial_reset_n)
      || ($past(read_clock) && !$past(read_clock, 2)))
    else $error("half full rose without read edge");
  hf_fall_a: assert property (
    $fell(half_full_flag_n) |-> $past(write_clock)
      && !$past(write_clock, 2))
    else $error("half full fell without write edge");
  ff_edge_a: assert property (
    $changed(full_flag_n) |-> !$past(master_reset_n)
      || !$past(partial_reset_n)
      || ($past(write_clock) && !$past(write_clock, 2)))
    else $error("full flag moved without write edge");
endmodule : frc_link_props

/* File: test/tb_top.sv */
/*
  Bench: host and device joined by the link, driven by host commands.
  Assumes DEPTH 16 on both ends and a 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
  import frc_pkg::*;
  ;
  localparam int DEPTH_TB = 16;
  typedef struct packed {
    frc_op_t op;
    logic [8:0] d;
    logic [8:0] q;
    logic [6:0] f;
    logic [6:0] m;
  } frc_row_t;
  logic clk;
  logic reset_n;
  logic cmd_valid;
  frc_op_t cmd_op;
  logic [DATA_W-1:0] cmd_data;
  logic cmd_fall_through_mode;
  logic cmd_load_n;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_refused;
  logic [DATA_W-1:0] rsp_data;
  logic [6:0] rsp_flags;
  logic fall_through_mode_active;
  logic [$clog2(DEPTH_TB+2)-1:0] occupancy;
  logic [8:0] rd;
  logic [6:0] rf;
  logic rr;
  int num_errors = 0;
  int total_checks = 0;
  frc_row_t rows [14] = '{
    '{FRC_OP_MASTER_RESET, 9'h000, 9'h000, 7'h6E, 7'h7F},
    '{FRC_OP_WRITE, 9'h101, 9'h000, 7'h4E, 7'h7F},
    '{FRC_OP_WRITE, 9'h0A2, 9'h000, 7'h4E, 7'h4F},
    '{FRC_OP_WRITE, 9'h1F3, 9'h000, 7'h4E, 7'h4F},
    '{FRC_OP_RCLK, 9'h000, 9'h000, 7'h4E, 7'h4E},
    '{FRC_OP_RCLK, 9'h000, 9'h000, 7'h4F, 7'h4F},
    '{FRC_OP_READ, 9'h000, 9'h101, 7'h4F, 7'h4F},
    '{FRC_OP_READ, 9'h000, 9'h0A2, 7'h4F, 7'h4F},
    '{FRC_OP_RETRANSMIT, 9'h000, 9'h0A2, 7'h4E, 7'h4F},
    '{FRC_OP_RCLK, 9'h000, 9'h0A2, 7'h4E, 7'h4F},
    '{FRC_OP_RCLK, 9'h000, 9'h0A2, 7'h4F, 7'h4F},
    '{FRC_OP_READ, 9'h000, 9'h101, 7'h4F, 7'h4F},
    '{FRC_OP_READ, 9'h000, 9'h0A2, 7'h4F, 7'h4F},
    '{FRC_OP_READ, 9'h000, 9'h1F3, 7'h4E, 7'h4E}
  };
  frc_if u_frc_if();
  frc_device #(.DEPTH(DEPTH_TB)) u_frc_device (
    .CLK(clk), .RESET_N(reset_n), .LINK(u_frc_if),
    .FALL_THROUGH_MODE_ACTIVE(fall_through_mode_active), .OCCUPANCY(occupancy));
  frc_host #(.DEPTH(DEPTH_TB)) u_frc_host (
    .CLK(clk), .RESET_N(reset_n), .LINK(u_frc_if), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_FALL_THROUGH_MODE(cmd_fall_through_mode),
    .CMD_LOAD_N(cmd_load_n), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_REFUSED(rsp_refused), .RSP_DATA(rsp_data), .RSP_FLAGS(rsp_flags));
  frc_link_props u_frc_link_props (
    .CLK(clk), .RESET_N(reset_n), .write_clock(u_frc_if.write_clock),
    .write_enable_n(u_frc_if.write_enable_n),
    .read_clock(u_frc_if.read_clock), .retransmit_n(u_frc_if.retransmit_n),
    .master_reset_n(u_frc_if.master_reset_n),
    .partial_reset_n(u_frc_if.partial_reset_n),
    .mode_select_serial_in(u_frc_if.mode_select_serial_in),
    .data_out(u_frc_if.data_out), .empty_flag_n(u_frc_if.empty_flag_n),
    .output_ready_n(u_frc_if.output_ready_n),
    .full_flag_n(u_frc_if.full_flag_n),
    .input_ready_n(u_frc_if.input_ready_n),
    .almost_empty_flag_n(u_frc_if.almost_empty_flag_n),
    .almost_full_flag_n(u_frc_if.almost_full_flag_n),
    .half_full_flag_n(u_frc_if.half_full_flag_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic cmd(input frc_op_t op, input logic [8:0] d,
                     input logic fw = 1'b0, input logic ln = 1'b0);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_fall_through_mode <= fw;
    cmd_load_n <= ln;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    chk(9'(rsp_valid), 9'h001);
    rd = rsp_data;
    rf = rsp_flags;
    rr = rsp_refused;
  endtask : cmd
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = FRC_OP_RCLK;
    cmd_data = 9'h000;
    cmd_fall_through_mode = 1'b0;
    cmd_load_n = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].d);
      chk(rd, rows[i].q);
      chk(9'(rf & rows[i].m), 9'(rows[i].f));
      chk(9'(rr), 9'h000);
    end
    $display("table done");
    cmd(FRC_OP_READ, 9'h000);
    chk(rd, 9'h1F3);
    chk(9'(occupancy), 9'h000);
    cmd(FRC_OP_PARTIAL_RESET, 9'h000);
    chk(rd, 9'h000);
    chk(9'(rf & 7'h7F), 9'h06E);
    chk(9'(fall_through_mode_active), 9'h000);
    cmd(FRC_OP_RETRANSMIT, 9'h000);
    chk(9'(rr), 9'h001);
    $display("partial reset done");
    for (int i = 0; i <= DEPTH_TB; i++) cmd(FRC_OP_WRITE, 9'(i + 32));
    chk(9'(rf[2]), 9'h000);
    chk(9'(occupancy), 9'(DEPTH_TB));
    cmd(FRC_OP_WCLK, 9'h000);
    chk(9'(occupancy), 9'(DEPTH_TB));
    chk(9'(rf[2]), 9'h000);
    cmd(FRC_OP_RCLK, 9'h000);
    cmd(FRC_OP_RCLK, 9'h000);
    for (int i = 0; i <= DEPTH_TB; i++) begin
      cmd(FRC_OP_READ, 9'h000);
      chk(rd, 9'(32 + (i < DEPTH_TB ? i : DEPTH_TB - 1)));
    end
    $display("full and empty done");
    cmd(FRC_OP_MASTER_RESET, 9'h000, 1'b1, 1'b1);
    chk(9'(fall_through_mode_active), 9'h001);
    chk(9'(rf & 7'h7F), 9'h067);
    cmd(FRC_OP_WRITE, 9'h155);
    cmd(FRC_OP_WRITE, 9'h0AB);
    cmd(FRC_OP_WRITE, 9'h1C4);
    cmd(FRC_OP_RCLK, 9'h000);
    cmd(FRC_OP_RCLK, 9'h000);
    chk(9'(rf[1]), 9'h001);
    cmd(FRC_OP_RCLK, 9'h000);
    chk(rd, 9'h155);
    chk(9'(rf[1]), 9'h000);
    cmd(FRC_OP_READ, 9'h000);
    chk(rd, 9'h0AB);
    cmd(FRC_OP_READ, 9'h000);
    chk(rd, 9'h1C4);
    cmd(FRC_OP_RETRANSMIT, 9'h000);
    chk(9'(rf[1]), 9'h001);
    cmd(FRC_OP_RCLK, 9'h000);
    cmd(FRC_OP_RCLK, 9'h000);
    chk(rd, 9'h155);
    chk(9'(rf[1]), 9'h000);
    cmd(FRC_OP_READ, 9'h000);
    chk(rd, 9'h0AB);
    $display("fall-through done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    cmd(FRC_OP_WRITE, 9'h0FF);
    chk(9'(fall_through_mode_active), 9'h000);
    chk(9'(occupancy), 9'h000);
    $display("power-up write done");
    summarize();
  end
endmodule : tb_top
